// file: verilog/usf_pkg.sv
// Package for the serial status flag block: offsets, bit positions, carriers, timing.
package usf_pkg;

    // ========================================================================
    // Register map (byte addresses on the APB slave)
    localparam logic [7:0] USF_ADDR_STATUS = 8'h00;
    localparam logic [7:0] USF_ADDR_DATA = 8'h04;
    localparam logic [7:0] USF_ADDR_CTRL = 8'h08;
    localparam logic [7:0] USF_ADDR_TXCTL = 8'h0C;

    // ========================================================================
    // Status bit positions
    localparam int USF_BIT_TDE = 7;
    localparam int USF_BIT_TC = 6;
    localparam int USF_BIT_RXF = 5;
    localparam int USF_BIT_IDLE = 4;
    localparam int USF_BIT_LOST = 3;
    localparam int USF_BIT_NOISE = 2;
    localparam int USF_BIT_FRAME = 1;
    localparam int USF_BIT_PAR = 0;

    // Control register bit positions
    localparam int USF_CTL_NINTH = 0;
    localparam int USF_CTL_ILT = 1;
    localparam int USF_CTL_PE = 2;
    localparam int USF_CTL_PODD = 3;
    localparam int USF_CTL_TXON = 4;
    localparam int USF_CTL_BRK = 5;

    // Reset values
    localparam logic [7:0] USF_STATUS_RST = 8'hC0;
    localparam logic [5:0] USF_CTRL_RST = 6'h00;

    // ========================================================================
    // Timing: 16 samples per bit, fixed divider from pclk
    localparam int USF_PCLK_HZ = 40000000;
    localparam int USF_BAUD = 115200;
    localparam logic [15:0] USF_SAMPLE_DIV = 16'(USF_PCLK_HZ / (USF_BAUD * 16));
    localparam logic [3:0] USF_SAMPLES_MAX = 4'hF;
    localparam logic [3:0] USF_IDLE_BITS = 4'hA;
    localparam logic [3:0] USF_IDLE_BITS9 = 4'hB;
    localparam logic [3:0] USF_DATA_BITS = 4'h8;
    localparam logic [3:0] USF_START_PH_LO = 4'h3;
    localparam logic [3:0] USF_START_PH_HI = 4'h9;
    localparam logic [3:0] USF_BIT_PH_LO = 4'h7;
    localparam logic [3:0] USF_BIT_PH_HI = 4'h9;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic [7:0] data;
        logic noise;
        logic frame;
        logic parity;
    } usf_rxchar_t;

    typedef struct packed {
        logic ninth;
        logic idle_count_select;
        logic pe;
        logic podd;
    } usf_cfg_t;

    typedef enum logic [4:0] {
        USF_RX_IDLE = 5'h01,
        USF_RX_START = 5'h02,
        USF_RX_DATA = 5'h04,
        USF_RX_STOP = 5'h08,
        USF_RX_DONE = 5'h10
    } usf_rx_state_t;

endpackage

// file: verilog/usf_status.sv
// Status flag logic of an asynchronous serial interface with its APB slave.
//
// Overview of operation
// - Status register read-only; writes ignored.
// - Transmit empty set at reset and buffer move.
// - Armed status read, data write clears tx empty.
// - Tx complete set when empty and idle.
// - Armed tx complete cleared by write/enable/break.
// - Rx full set when character lands in data.
// - Armed status read, data read clears rx full.
// - Idle set after 10 or 11 high bits.
// - Select 0: count idle from after start bit.
// - Select 1: count idle after stop bit.
// - Armed read sequence clears idle flag.
// - Idle sets once per received character.
// - Overrun sets lost flag, drops new character.
// - Armed read sequence clears lost flag.
// - Seven/three samples; disagreement sets noise flag.
// - Read sequence clears noise flag.
// - Zero at stop bit sets framing flag.
// - Parity mismatch with enable sets parity flag.
// - Read sequence clears parity flag.
// - Ninth bit select adds one bit time.
// - Enable low then high queues idle character.
`timescale 1ns/100ps

module usf_status
    import usf_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic rxd,
    output logic txd
);

    // ========================================================================
    // Bus decode
    logic acc;
    logic rd_status;
    logic rd_data;
    logic wr_data;
    logic wr_ctrl;
    logic [7:0] status_one_reg;
    logic [5:0] ctrl_q;
    logic [7:0] rx_data_q;
    logic [7:0] armed_q;
    logic busy;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    assign acc = psel && penable;
    assign pready = 1'b1; // Zero wait states
    assign pslverr = acc && !(hit(paddr, USF_ADDR_STATUS) || hit(paddr, USF_ADDR_DATA)
                     || hit(paddr, USF_ADDR_CTRL) || hit(paddr, USF_ADDR_TXCTL));
    assign rd_status = acc && !pwrite && hit(paddr, USF_ADDR_STATUS);
    assign rd_data = acc && !pwrite && hit(paddr, USF_ADDR_DATA);
    assign wr_data = acc && pwrite && hit(paddr, USF_ADDR_DATA) && !busy;
    assign wr_ctrl = acc && pwrite && hit(paddr, USF_ADDR_CTRL);

    // Read data is registered; writes to status fall through untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h00000000;
            if (hit(paddr, USF_ADDR_STATUS))
                prdata[7:0] <= status_one_reg;
            else if (hit(paddr, USF_ADDR_DATA))
                prdata[7:0] <= rx_data_q;
            else if (hit(paddr, USF_ADDR_CTRL))
                prdata[5:0] <= ctrl_q;
        end
    end

    // Control bits; break_queue and tx_on live here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= USF_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= pwdata[5:0];
    end

    usf_cfg_t cfg;
    assign cfg = '{ninth: ctrl_q[USF_CTL_NINTH], idle_count_select: ctrl_q[USF_CTL_ILT],
                   pe: ctrl_q[USF_CTL_PE], podd: ctrl_q[USF_CTL_PODD]};
    logic tx_on;
    logic break_queue;
    logic txon_rise;
    logic brk_wr;
    assign tx_on = ctrl_q[USF_CTL_TXON];
    assign break_queue = ctrl_q[USF_CTL_BRK];
    assign txon_rise = wr_ctrl && !tx_on && pwdata[USF_CTL_TXON];
    assign brk_wr = wr_ctrl && pwdata[USF_CTL_BRK];

    // ========================================================================
    // Sample tick shared by both directions
    logic [15:0] div_q;
    logic tick;
    assign tick = (div_q == 16'h0000);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 16'h0000;
        else
            div_q <= tick ? USF_SAMPLE_DIV - 16'h0001 : div_q - 16'h0001;
    end

    // ========================================================================
    // Transmitter: one-word buffer, shifter, preamble/idle and break queueing
    logic [7:0] txbuf_q;
    logic txfull_q;
    logic [10:0] tsh_q;
    logic [3:0] tbits_q;
    logic [3:0] tph_q;
    logic tact_q;
    logic pre_q;
    logic [3:0] fr_bits;
    logic load;
    logic txpar;
    assign fr_bits = cfg.ninth ? USF_IDLE_BITS9 : USF_IDLE_BITS;
    assign busy = txfull_q;
    assign txpar = (^txbuf_q) ^ cfg.podd;
    assign load = tick && !tact_q && tx_on && (txfull_q || pre_q || break_queue);

    // Queued idle on a tx_on re-enable; break when break_queue held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_q <= 1'b0;
        else if (txon_rise)
            pre_q <= 1'b1;
        else if (load && !txfull_q)
            pre_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txbuf_q <= 8'h00;
            txfull_q <= 1'b0;
        end
        else if (wr_data)
        begin
            txbuf_q <= pwdata[7:0];
            txfull_q <= 1'b1;
        end
        else if (load && !pre_q && !break_queue)
            txfull_q <= 1'b0;
    end

    // Shifter sends LSB first, 16 ticks per bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tsh_q <= 11'h7FF;
            tbits_q <= 4'h0;
            tph_q <= 4'h0;
            tact_q <= 1'b0;
        end
        else if (load)
        begin
            tact_q <= 1'b1;
            tph_q <= 4'h0;
            tbits_q <= fr_bits;
            if (pre_q)
                tsh_q <= 11'h7FF;
            else if (break_queue)
                tsh_q <= {!cfg.ninth, 10'h000}; // Line back high once the break ends
            else
                tsh_q <= {1'b1, cfg.pe ? txpar : 1'b1, txbuf_q, 1'b0};
        end
        else if (tick && tact_q)
        begin
            tph_q <= tph_q + 4'h1;
            if (tph_q == USF_SAMPLES_MAX)
            begin
                tsh_q <= {1'b1, tsh_q[10:1]};
                tbits_q <= tbits_q - 4'h1;
                if (tbits_q == 4'h1)
                    tact_q <= 1'b0;
            end
        end
    end
    assign txd = tsh_q[0];

    // ========================================================================
    // Receiver: two-flop synchroniser, then sampler
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_prev_q;
    // Start needs a falling edge, so a line held low after a frame is no new start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rxd;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
        end
    end

    usf_rx_state_t rst_q;
    logic [3:0] rph_q;
    logic [3:0] rbit_q;
    logic [8:0] rsh_q;
    logic [2:0] ones_q;
    logic [2:0] zeros_q;
    logic noise_q;
    logic in_win;
    logic bit_end;
    logic bit_val;
    logic bit_noisy;
    logic [3:0] data_n;
    usf_rxchar_t rx_char;
    logic rx_done;

    assign data_n = cfg.pe ? USF_DATA_BITS + 4'h1 : USF_DATA_BITS;
    assign in_win = (rst_q == USF_RX_START)
                    ? (rph_q >= USF_START_PH_LO && rph_q <= USF_START_PH_HI)
                    : (rph_q >= USF_BIT_PH_LO && rph_q <= USF_BIT_PH_HI);
    assign bit_end = tick && rph_q == USF_SAMPLES_MAX;
    assign bit_val = ones_q > zeros_q;
    assign bit_noisy = (ones_q != 3'h0) && (zeros_q != 3'h0);
    assign rx_done = (rst_q == USF_RX_DONE);

    // Majority vote per bit; seven samples in start, three elsewhere
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_q <= USF_RX_IDLE;
            rph_q <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q <= 9'h000;
            ones_q <= 3'h0;
            zeros_q <= 3'h0;
            noise_q <= 1'b0;
        end
        else
        begin
            if (tick && rst_q != USF_RX_IDLE && rst_q != USF_RX_DONE)
            begin
                rph_q <= rph_q + 4'h1;
                if (bit_end)
                begin
                    ones_q <= 3'h0;
                    zeros_q <= 3'h0;
                end
                else if (in_win && rx_s2_q)
                    ones_q <= ones_q + 3'h1;
                else if (in_win)
                    zeros_q <= zeros_q + 3'h1;
            end
            unique case (rst_q)
                USF_RX_IDLE:
                    if (!rx_s2_q && rx_prev_q)
                    begin
                        rst_q <= USF_RX_START;
                        rph_q <= 4'h0;
                        noise_q <= 1'b0;
                        ones_q <= 3'h0;
                        zeros_q <= 3'h0;
                    end
                USF_RX_START:
                    if (bit_end)
                    begin
                        noise_q <= bit_noisy;
                        rbit_q <= 4'h0;
                        rst_q <= bit_val ? USF_RX_IDLE : USF_RX_DATA;
                    end
                USF_RX_DATA:
                    if (bit_end)
                    begin
                        noise_q <= noise_q | bit_noisy;
                        rsh_q <= {bit_val, rsh_q[8:1]};
                        rbit_q <= rbit_q + 4'h1;
                        if (rbit_q + 4'h1 == data_n)
                            rst_q <= USF_RX_STOP;
                    end
                USF_RX_STOP:
                    if (bit_end)
                    begin
                        noise_q <= noise_q | bit_noisy;
                        rsh_q <= cfg.pe ? rsh_q : {1'b0, rsh_q[8:1]};
                        ones_q <= {2'b00, bit_val}; // Stop value kept for framing
                        rst_q <= USF_RX_DONE;
                    end
                USF_RX_DONE:
                    rst_q <= USF_RX_IDLE;
                default:
                    rst_q <= USF_RX_IDLE;
            endcase
        end
    end

    assign rx_char.data = rsh_q[7:0];
    assign rx_char.noise = noise_q;
    assign rx_char.frame = !ones_q[0];
    assign rx_char.parity = cfg.pe && ((^rsh_q) != cfg.podd);

    // ========================================================================
    // Idle-line counter
    logic [3:0] idle_cnt_q;
    logic [3:0] rph_idle_q;
    logic idle_ok_q;
    logic idle_hit;
    logic count_en;
    // Select 0 counts high bits from after the start bit; select 1 only once back idle
    assign count_en = cfg.idle_count_select ? (rst_q == USF_RX_IDLE) : (rst_q != USF_RX_START);
    assign idle_hit = idle_cnt_q == fr_bits;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idle_cnt_q <= 4'h0;
            rph_idle_q <= 4'h0;
        end
        else if (!rx_s2_q || !count_en)
        begin
            idle_cnt_q <= 4'h0;
            rph_idle_q <= 4'h0;
        end
        else if (tick && !idle_hit)
        begin
            rph_idle_q <= rph_idle_q + 4'h1;
            if (rph_idle_q == USF_SAMPLES_MAX)
                idle_cnt_q <= idle_cnt_q + 4'h1;
        end
    end

    // ========================================================================
    // Status flags: set wins over an armed clear
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] flags_q;
    logic take;
    logic tx_idle;
    assign take = rx_done && !flags_q[USF_BIT_RXF];
    assign tx_idle = !tact_q && !txfull_q && !pre_q && !(break_queue && tx_on);

    always_comb
    begin
        set_v = 8'h00;
        // Level sets yield in the cycle of their own clearing action
        set_v[USF_BIT_TDE] = !txfull_q && !wr_data;
        set_v[USF_BIT_TC] = tx_idle && !(wr_data || txon_rise || brk_wr);
        set_v[USF_BIT_RXF] = take;
        set_v[USF_BIT_IDLE] = idle_hit && idle_ok_q;
        set_v[USF_BIT_LOST] = rx_done && flags_q[USF_BIT_RXF];
        set_v[USF_BIT_NOISE] = take && rx_char.noise;
        set_v[USF_BIT_FRAME] = take && rx_char.frame;
        set_v[USF_BIT_PAR] = take && rx_char.parity;
        clr_v = 8'h00;
        clr_v[USF_BIT_TDE] = wr_data;
        clr_v[USF_BIT_TC] = wr_data || txon_rise || brk_wr;
        clr_v[USF_BIT_RXF] = rd_data;
        clr_v[USF_BIT_IDLE] = rd_data;
        clr_v[USF_BIT_LOST] = rd_data;
        clr_v[USF_BIT_NOISE] = rd_data;
        clr_v[USF_BIT_FRAME] = rd_data;
        clr_v[USF_BIT_PAR] = rd_data;
        clr_v = clr_v & armed_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= USF_STATUS_RST;
        else
            flags_q <= set_v | (flags_q & ~clr_v);
    end
    assign status_one_reg = flags_q;

    // Arming: only flags seen at one by a status read; dropped once used
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed_q <= 8'h00;
        else if (rd_status)
            armed_q <= prdata[7:0];
        else
            armed_q <= armed_q & ~clr_v & flags_q;
    end

    // Idle may fire once per received character
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_ok_q <= 1'b0;
        else if (take)
            idle_ok_q <= 1'b1;
        else if (idle_hit && idle_ok_q)
            idle_ok_q <= 1'b0;
    end

    // Received data lands only when the register is free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_data_q <= 8'h00;
        else if (take)
            rx_data_q <= rx_char.data;
    end

endmodule

// file: test/usf_status_chk.sv
// Port checker for the serial status flag block.
`timescale 1ns/100ps
module usf_status_chk
    import usf_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial line
    input wire logic rxd,
    input wire logic txd
);
    // ========
    // Access decode
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic st_rd;
    assign acc = psel && penable;
    assign st_rd = acc && !pwrite && (paddr == USF_ADDR_STATUS);

    // ========
    // Bus answers
    a_ready_in_access: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (acc && paddr > USF_ADDR_TXCTL |-> pslverr)
        else $error("no slave error on unmapped access");
    a_err_mapped: assert property (acc && paddr[1:0] == 2'h0 && paddr <= USF_ADDR_CTRL |-> !pslverr)
        else $error("slave error on mapped access");
    a_status_upper_zero: assert property (st_rd |-> prdata[31:8] == 24'h0)
        else $error("status shows upper bits");
    a_rsvd_reads_zero: assert property (acc && !pwrite && paddr == USF_ADDR_TXCTL
        |-> prdata == 32'h0)
        else $error("reserved word not zero");

    // ========
    // Flag relations seen by a status read
    a_err_with_full: assert property (st_rd && |prdata[2:0] |-> prdata[USF_BIT_RXF])
        else $error("error flag without receive full");
    a_lost_with_full: assert property (st_rd && prdata[USF_BIT_LOST] |-> prdata[USF_BIT_RXF])
        else $error("overrun without receive full");
    a_tc_needs_empty: assert property (st_rd && prdata[USF_BIT_TC] |-> prdata[USF_BIT_TDE])
        else $error("complete while buffer full");
    a_tc_line_idle: assert property (st_rd && prdata[USF_BIT_TC] |-> txd)
        else $error("complete while line active");
    // A start bit is a whole bit time, far above eight cycles
    a_start_bit_len: assert property ($fell(txd) |-> !txd [*8])
        else $error("short low pulse on txd");

    // ========
    // Main scenarios
    c_overrun: cover property (st_rd && prdata[USF_BIT_LOST]);
    c_noise: cover property (st_rd && prdata[USF_BIT_NOISE]);
    c_tx_start: cover property ($fell(txd));
endmodule

// file: test/usf_remote.sv
// Remote serial partner: sends frames on rxd, decodes frames from txd.
`timescale 1ns/100ps
module usf_remote
    import usf_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Serial lines
    input wire logic txd,
    output logic rxd
);
    // ========
    // Frame timing and decoded results
    localparam int BIT_CYC = int'(USF_SAMPLE_DIV) * 16;
    logic [7:0] got_q;
    int got_n;
    initial rxd = 1'b1;

    // One frame, LSB first; glitch flips one middle sample of a bit
    task automatic send(input logic [7:0] d, input logic pen, input logic pbad,
        input logic stop_v, input int glitch);
        logic b;
        for (int i = 0; i < (pen ? 11 : 10); i++)
        begin
            if (i == 0)
                b = 1'b0;
            else if (i <= 8)
                b = d[i-1];
            else if (i == 9 && pen)
                b = ^d ^ pbad;
            else
                b = stop_v;
            for (int k = 0; k < BIT_CYC; k++)
            begin
                @(posedge pclk);
                rxd <= (i == glitch && k >= 168 && k < 189) ? !b : b;
            end
        end
        @(posedge pclk);
        rxd <= 1'b1;
        // Half a bit of idle so the flags have landed before the bench reads them
        repeat (BIT_CYC / 2) @(posedge pclk);
    endtask

    // Mid-bit decoder; frames with a low stop bit are not counted
    initial
    begin
        got_n = 0;
        forever
        begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(posedge pclk);
                got_q[i] = txd;
            end
            repeat (BIT_CYC) @(posedge pclk);
            if (txd === 1'b1)
                got_n++;
        end
    end
endmodule

// file: test/usf_status_tb.sv
// Self-checking bench for the serial status flag block.
`timescale 1ns/100ps
module usf_status_tb
    import usf_pkg::*;
();
    // ========
    // Signals
    localparam int BIT_CYC = int'(USF_SAMPLE_DIV) * 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    int fails = 0;
    int total_checks = 0;

    usf_status usf_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
    usf_remote usf_remote_inst (.pclk(pclk), .txd(txd), .rxd(rxd));

    // 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ========
    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        rdv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
            fails++;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: read %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic look(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdv & mask, exp);
    endtask

    task automatic bits(input int n);
        repeat (n * BIT_CYC) @(posedge pclk);
    endtask

    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well above the expected run of about 73000 cycles
    initial
    begin
        repeat (90000) @(posedge pclk);
        fails++;
        results();
    end

    // ========
    // Tests
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        look(USF_ADDR_STATUS, 32'hFF, 32'hC0);
        apb(1'b1, USF_ADDR_STATUS, 32'h0);
        look(USF_ADDR_STATUS, 32'hFF, 32'hC0);
        look(USF_ADDR_TXCTL, 32'hFFFFFFFF, 32'h0);
        look(8'h20, 32'hFFFFFFFF, 32'h0);
        check({31'h0, last_err}, 32'h1);
        // Receive, unarmed data read, then the armed clear
        apb(1'b1, USF_ADDR_CTRL, 32'h10);
        usf_remote_inst.send(8'h5A, 1'b0, 1'b0, 1'b1, 99);
        apb(1'b0, USF_ADDR_DATA, 32'h0);
        look(USF_ADDR_STATUS, 32'h20, 32'h20);
        look(USF_ADDR_DATA, 32'hFF, 32'h5A);
        look(USF_ADDR_STATUS, 32'h20, 32'h00);
        bits(11);
        look(USF_ADDR_STATUS, 32'h10, 32'h10);
        apb(1'b0, USF_ADDR_DATA, 32'h0);
        bits(12);
        look(USF_ADDR_STATUS, 32'h10, 32'h00);
        // Idle count start point, both selections
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, USF_ADDR_CTRL, m == 1 ? 32'h12 : (m == 2 ? 32'h11 : 32'h10));
            usf_remote_inst.send(8'hFF, 1'b0, 1'b0, 1'b1, 99);
            bits(1);
            look(USF_ADDR_STATUS, 32'h10, m == 0 ? 32'h10 : 32'h00);
            bits(11);
            look(USF_ADDR_STATUS, 32'h30, 32'h30);
            apb(1'b0, USF_ADDR_DATA, 32'h0);
        end
        // Overrun keeps the first character
        apb(1'b1, USF_ADDR_CTRL, 32'h10);
        usf_remote_inst.send(8'h11, 1'b0, 1'b0, 1'b1, 99);
        usf_remote_inst.send(8'h22, 1'b0, 1'b0, 1'b1, 99);
        look(USF_ADDR_STATUS, 32'h28, 32'h28);
        look(USF_ADDR_DATA, 32'hFF, 32'h11);
        look(USF_ADDR_STATUS, 32'h28, 32'h00);
        // Noise, framing and parity errors in turn
        for (int m = 0; m < 3; m++)
        begin
            apb(1'b1, USF_ADDR_CTRL, m == 2 ? 32'h14 : 32'h10);
            usf_remote_inst.send(8'h0F, m == 2, m == 2, m != 1, m == 0 ? 3 : 99);
            look(USF_ADDR_STATUS, 32'h27, 32'h20 | (32'h04 >> m));
            apb(1'b0, USF_ADDR_DATA, 32'h0);
            look(USF_ADDR_STATUS, 32'h27, 32'h00);
        end
        // Transmit two characters back to back
        apb(1'b1, USF_ADDR_CTRL, 32'h10);
        look(USF_ADDR_STATUS, 32'hC0, 32'hC0);
        apb(1'b1, USF_ADDR_DATA, 32'h3C);
        bits(1);
        look(USF_ADDR_STATUS, 32'h40, 32'h00);
        apb(1'b1, USF_ADDR_DATA, 32'h3D);
        look(USF_ADDR_STATUS, 32'h80, 32'h00);
        bits(23);
        check({24'h0, usf_remote_inst.got_q}, 32'h3D);
        check(32'(usf_remote_inst.got_n), 32'h2);
        look(USF_ADDR_STATUS, 32'hC0, 32'hC0);
        // Preamble by enable low then high
        apb(1'b1, USF_ADDR_CTRL, 32'h00);
        apb(1'b1, USF_ADDR_CTRL, 32'h10);
        look(USF_ADDR_STATUS, 32'h40, 32'h00);
        bits(12);
        look(USF_ADDR_STATUS, 32'h40, 32'h40);
        // Break request
        apb(1'b1, USF_ADDR_CTRL, 32'h30);
        look(USF_ADDR_STATUS, 32'h40, 32'h00);
        bits(2);
        check({31'h0, txd}, 32'h0);
        apb(1'b1, USF_ADDR_CTRL, 32'h10);
        bits(24);
        look(USF_ADDR_STATUS, 32'h40, 32'h40);
        results();
    end
endmodule

bind usf_status usf_status_chk usf_status_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
